//--- rtl/ssfm_top.v
// Purpose: Safe-stop power cut, feedback, fault gating, position error
// Assumes: Channel pins high when ON (closed), low when released
// Notes:   Timing counted on a 1 us tick enable
//
// The address map and the APB slave port are this design's own decisions.
`default_nettype none
`include "ssfm_defines.vh"

module ssfm_top #(
  parameter FILT_TICKS = `SSFM_FILT_TIME_US,
  parameter SKEW_TICKS = `SSFM_SKEW_TIME_S * 1000000,
  parameter ERR_W      = 32
) (
  // Clock and reset
  input  wire        sys_clk_i,
  input  wire        rst_n_i,
  // Safety channels and feedback
  input  wire        safe_stop_in_a_i,
  input  wire        safe_stop_in_b_i,
  output reg         stop_feedback_out_o,
  // Host controls
  input  wire        drive_on_req_i,
  input  wire        error_clear_in_i,
  input  wire        pos_ref_pulse_i,
  input  wire        pos_ref_dir_i,
  // Drive side
  output reg         motor_current_en_o,
  output reg         move_step_o,
  output reg         move_dir_o,
  output reg         cut_display_o,
  output reg  [1:0]  safe_input_monitor_o,
  // Fault pins
  output reg         fault_out_o,
  output reg         fault_code_out_1_o,
  output reg         fault_code_out_2_o,
  output reg         fault_code_out_3_o,
  output reg         fault_oe_o,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Interrupt
  output reg         irq_o
);

////////////////////////////////////////////////////////////////////////////////
localparam ST_IDLE = 2'h0;
localparam ST_RUN  = 2'h1;
localparam ST_CUT  = 2'h2;

function [ERR_W-1:0] ssfm_mag;
  input [ERR_W-1:0] v;
  begin
    ssfm_mag = v[ERR_W-1] ? (~v + {{(ERR_W-1){1'b0}}, 1'b1}) : v;
  end
endfunction

function ssfm_mapped;
  input [11:0] a;
  begin
    case (a)
      `SSFM_REG_CTRL, `SSFM_REG_OVF_LIMIT, `SSFM_REG_STATUS, `SSFM_REG_POS_ERR,
      `SSFM_REG_IRQ_STAT, `SSFM_REG_IRQ_CLR, `SSFM_REG_IRQ_EN,
      `SSFM_REG_FAULT_CLR: ssfm_mapped = 1'b1;
      default: ssfm_mapped = 1'b0;
    endcase
  end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers
wire [5:0] pins_s;

ssfm_sync #(
  .W (6)
) u_sync (
  .sys_clk_i (sys_clk_i),
  .rst_n_i   (rst_n_i),
  .async_i   ({pos_ref_dir_i, pos_ref_pulse_i, error_clear_in_i, drive_on_req_i,
                safe_stop_in_b_i, safe_stop_in_a_i}),
  .sync_o    (pins_s)
);

wire ch_a_on   = pins_s[0];
wire ch_b_on   = pins_s[1];
wire drive_on  = pins_s[2];
wire clr_in    = pins_s[3];
wire ref_pulse = pins_s[4];
wire ref_dir   = pins_s[5];

////////////////////////////////////////////////////////////////////////////////
// 1 us tick
reg  [7:0] tick_cnt;
wire       tick = (tick_cnt == `SSFM_TICK_CYC - 1);

always @(posedge sys_clk_i or negedge rst_n_i) begin
  if (!rst_n_i) begin
    tick_cnt <= 8'h00;
  end else if (tick) begin
    tick_cnt <= 8'h00;
  end else begin
    tick_cnt <= tick_cnt + 8'h01;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Release filter, short drops never reach the cut decision
reg [15:0] off_cnt_a;
reg [15:0] off_cnt_b;
reg        a_rel;
reg        b_rel;

always @(posedge sys_clk_i or negedge rst_n_i) begin
  if (!rst_n_i) begin
    off_cnt_a <= 16'h0000;
    off_cnt_b <= 16'h0000;
    a_rel     <= 1'b0;
    b_rel     <= 1'b0;
  end else begin
    if (ch_a_on) begin
      off_cnt_a <= 16'h0000;
      a_rel     <= 1'b0;
    end else if (tick && !a_rel) begin
      off_cnt_a <= off_cnt_a + 16'h0001;
      a_rel     <= (off_cnt_a >= FILT_TICKS[15:0]);
    end
    if (ch_b_on) begin
      off_cnt_b <= 16'h0000;
      b_rel     <= 1'b0;
    end else if (tick && !b_rel) begin
      off_cnt_b <= off_cnt_b + 16'h0001;
      b_rel     <= (off_cnt_b >= FILT_TICKS[15:0]);
    end
  end
end

wire cut_req  = a_rel | b_rel;
wire both_rel = a_rel & b_rel;

////////////////////////////////////////////////////////////////////////////////
// Channel skew watch
reg [23:0] skew_cnt;
reg        skew_hit;

always @(posedge sys_clk_i or negedge rst_n_i) begin
  if (!rst_n_i) begin
    skew_cnt <= 24'h00_0000;
    skew_hit <= 1'b0;
  end else begin
    skew_hit <= 1'b0;
    if (a_rel == b_rel) begin
      skew_cnt <= 24'h00_0000;
    end else if (tick && skew_cnt != SKEW_TICKS[23:0]) begin
      skew_cnt <= skew_cnt + 24'h00_0001;
      skew_hit <= (skew_cnt == SKEW_TICKS[23:0] - 24'h00_0001);
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// Drive state
reg [1:0] state;
reg [1:0] next_state;

always @* begin
  next_state = state;
  case (state)
    ST_IDLE: begin
      if (cut_req) begin
        next_state = ST_CUT;
      end else if (drive_on) begin
        next_state = ST_RUN;
      end
    end
    ST_RUN: begin
      if (cut_req) begin
        next_state = ST_CUT;
      end
    end
    ST_CUT: begin
      // Drive-on must drop before leaving the cut
      if (!cut_req && !drive_on) begin
        next_state = ST_IDLE;
      end
    end
    default: next_state = ST_IDLE;
  endcase
end

always @(posedge sys_clk_i or negedge rst_n_i) begin
  if (!rst_n_i) begin
    state <= ST_IDLE;
  end else begin
    state <= next_state;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Registers
reg             err_sel;
reg [ERR_W-1:0] ovf_limit;
reg [3:0]       irq_stat;
reg [3:0]       irq_en;
reg             skew_flt;
reg             ovr_flt;
reg [ERR_W-1:0] pos_err;

wire wr_done = psel & penable & pready & pwrite;
wire wr_ctrl = wr_done & (paddr == `SSFM_REG_CTRL);
wire wr_lim  = wr_done & (paddr == `SSFM_REG_OVF_LIMIT);
wire wr_iclr = wr_done & (paddr == `SSFM_REG_IRQ_CLR);
wire wr_ien  = wr_done & (paddr == `SSFM_REG_IRQ_EN);
wire wr_fclr = wr_done & (paddr == `SSFM_REG_FAULT_CLR);

wire in_cut  = (state == ST_CUT);
wire ovr_now = ssfm_mag(pos_err) > ovf_limit;

////////////////////////////////////////////////////////////////////////////////
// Position error
reg ref_prev;
wire ref_edge = ref_pulse & ~ref_prev;
wire step_now = (state == ST_RUN) && tick && (pos_err != {ERR_W{1'b0}});
reg [ERR_W-1:0] next_pos_err;

always @* begin
  next_pos_err = pos_err;
  if (ref_edge) begin
    next_pos_err = ref_dir ? next_pos_err - {{(ERR_W-1){1'b0}}, 1'b1}
                           : next_pos_err + {{(ERR_W-1){1'b0}}, 1'b1};
  end
  if (step_now) begin
    next_pos_err = pos_err[ERR_W-1] ? next_pos_err + {{(ERR_W-1){1'b0}}, 1'b1}
                                    : next_pos_err - {{(ERR_W-1){1'b0}}, 1'b1};
  end
  if (in_cut && !err_sel) begin
    next_pos_err = {ERR_W{1'b0}};
  end
  if (clr_in && (in_cut || state == ST_IDLE)) begin
    next_pos_err = {ERR_W{1'b0}};
  end
end

always @(posedge sys_clk_i or negedge rst_n_i) begin
  if (!rst_n_i) begin
    pos_err     <= {ERR_W{1'b0}};
    ref_prev    <= 1'b0;
    move_step_o <= 1'b0;
    move_dir_o  <= 1'b0;
  end else begin
    pos_err     <= next_pos_err;
    ref_prev    <= ref_pulse;
    move_step_o <= step_now;
    if (step_now) begin
      move_dir_o <= ~pos_err[ERR_W-1];
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// Faults, sticky until software clears; a new hit beats the clear
always @(posedge sys_clk_i or negedge rst_n_i) begin
  if (!rst_n_i) begin
    skew_flt <= 1'b0;
    ovr_flt  <= 1'b0;
  end else begin
    skew_flt <= skew_hit | (skew_flt & ~(wr_fclr & pwdata[`SSFM_EV_SKEW]));
    ovr_flt  <= ovr_now | (ovr_flt & ~(wr_fclr & pwdata[`SSFM_EV_OVR]));
  end
end

////////////////////////////////////////////////////////////////////////////////
// Pin outputs
always @(posedge sys_clk_i or negedge rst_n_i) begin
  if (!rst_n_i) begin
    stop_feedback_out_o  <= 1'b0;
    motor_current_en_o   <= 1'b0;
    cut_display_o        <= 1'b0;
    safe_input_monitor_o <= 2'h0;
    fault_out_o          <= 1'b0;
    fault_code_out_1_o   <= 1'b0;
    fault_code_out_2_o   <= 1'b0;
    fault_code_out_3_o   <= 1'b0;
    fault_oe_o           <= 1'b0;
  end else begin
    stop_feedback_out_o  <= both_rel;
    motor_current_en_o   <= (next_state == ST_RUN);
    cut_display_o        <= both_rel;
    safe_input_monitor_o <= {ch_b_on, ch_a_on};
    fault_oe_o           <= ~cut_req & ~in_cut;
    if (cut_req || in_cut) begin
      fault_out_o        <= 1'b0;
      fault_code_out_1_o <= 1'b0;
      fault_code_out_2_o <= 1'b0;
      fault_code_out_3_o <= 1'b0;
    end else begin
      fault_out_o        <= skew_flt | ovr_flt;
      {fault_code_out_3_o, fault_code_out_2_o, fault_code_out_1_o} <=
        ovr_flt ? `SSFM_CODE_OVR : (skew_flt ? `SSFM_CODE_SKEW : `SSFM_CODE_NONE);
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// Interrupt status, set wins over clear
reg        fb_prev;
reg  [3:0] ev;

always @* begin
  ev = 4'h0;
  ev[`SSFM_EV_CUT]  = (next_state == ST_CUT) && !in_cut;
  ev[`SSFM_EV_SKEW] = skew_hit;
  ev[`SSFM_EV_OVR]  = ovr_now && !ovr_flt;
  ev[`SSFM_EV_FB]   = both_rel ^ fb_prev;
end

always @(posedge sys_clk_i or negedge rst_n_i) begin
  if (!rst_n_i) begin
    irq_stat <= 4'h0;
    irq_en   <= `SSFM_IRQ_EN_RST;
    fb_prev  <= 1'b0;
    irq_o    <= 1'b0;
  end else begin
    fb_prev  <= both_rel;
    irq_stat <= ev | (irq_stat & ~({4{wr_iclr}} & pwdata[3:0]));
    if (wr_ien) begin
      irq_en <= pwdata[3:0];
    end
    irq_o    <= |(irq_stat & irq_en);
  end
end

////////////////////////////////////////////////////////////////////////////////
// APB slave, one wait state; read data caught in the setup cycle
reg [31:0] rd_mux;

always @* begin
  rd_mux = 32'h0000_0000;
  case (paddr)
    `SSFM_REG_CTRL:      rd_mux[`SSFM_CTRL_SEL_BIT] = err_sel;
    `SSFM_REG_OVF_LIMIT: rd_mux = ovf_limit;
    `SSFM_REG_STATUS:    rd_mux = {22'h00_0000, ovr_flt, skew_flt, both_rel, cut_req,
                                   ch_b_on, ch_a_on, 2'h0, state};
    `SSFM_REG_POS_ERR:   rd_mux = pos_err;
    `SSFM_REG_IRQ_STAT:  rd_mux[3:0] = irq_stat;
    `SSFM_REG_IRQ_EN:    rd_mux[3:0] = irq_en;
    default:             rd_mux = 32'h0000_0000;
  endcase
end

always @(posedge sys_clk_i or negedge rst_n_i) begin
  if (!rst_n_i) begin
    prdata    <= 32'h0000_0000;
    pready    <= 1'b0;
    pslverr   <= 1'b0;
    err_sel   <= `SSFM_CTRL_RST;
    ovf_limit <= `SSFM_OVF_LIMIT_RST;
  end else begin
    pready  <= psel & penable & ~pready;
    pslverr <= psel & penable & ~pready & ~ssfm_mapped(paddr);
    if (psel && !penable) begin
      prdata <= rd_mux;
    end
    if (wr_ctrl) begin
      err_sel <= pwdata[`SSFM_CTRL_SEL_BIT];
    end
    if (wr_lim) begin
      ovf_limit <= pwdata;
    end
  end
end

endmodule
`default_nettype wire

//--- rtl/ssfm_defines.vh
// Purpose: Constants of the safe-stop feedback monitor
// Assumes: 200 MHz system clock, 1 us timing tick
// Notes:   Offsets are APB byte addresses
//
// What this block does
// - Either channel released enters power cut
// - Lone released channel for 10 s: skew fault
// - Releases of 0.5 ms or less ignored
// - Clear or keep error per select
// - Select 1 keeps accumulating references during cut
// - Error over limit raises overrun fault
// - Next drive-on moves by retained error
// - Clear input in cut/idle clears error
// - Fault and code outputs undriven during cut
// - Feedback high only when both released
// - Feedback follows channels within 20 ms
// - Both released: cut display, motor off
// - Monitor shows each channel's state
`ifndef SSFM_DEFINES_VH
`define SSFM_DEFINES_VH

////////////////////////////////////////////////////////////////////////////////
`define SSFM_CLK_MHZ        200
`define SSFM_TICK_TIME_US   1
`define SSFM_TICK_CYC       (`SSFM_CLK_MHZ * `SSFM_TICK_TIME_US)
`define SSFM_FILT_TIME_US   500
`define SSFM_SKEW_TIME_S    10
`define SSFM_FB_MAX_TIME_MS 20

////////////////////////////////////////////////////////////////////////////////
`define SSFM_REG_CTRL      12'h000
`define SSFM_REG_OVF_LIMIT 12'h004
`define SSFM_REG_STATUS    12'h008
`define SSFM_REG_POS_ERR   12'h00C
`define SSFM_REG_IRQ_STAT  12'h010
`define SSFM_REG_IRQ_CLR   12'h014
`define SSFM_REG_IRQ_EN    12'h018
`define SSFM_REG_FAULT_CLR 12'h01C

`define SSFM_CTRL_SEL_BIT    0
`define SSFM_CTRL_RST        1'h0
`define SSFM_OVF_LIMIT_RST   32'h0001_0000
`define SSFM_IRQ_EN_RST      4'h0

// Interrupt and fault-clear bit positions
`define SSFM_EV_CUT      0
`define SSFM_EV_SKEW     1
`define SSFM_EV_OVR      2
`define SSFM_EV_FB       3

// Fault codes on the three code pins
`define SSFM_CODE_NONE   3'h0
`define SSFM_CODE_SKEW   3'h1
`define SSFM_CODE_OVR    3'h2

`endif

//--- rtl/ssfm_sync.v
// Purpose: Three-stage pin synchroniser with agreement check
// Assumes: Inputs asynchronous to sys_clk_i
// Notes:   Output changes once stages two and three agree
`default_nettype none

module ssfm_sync #(
  parameter W = 1
) (
  // Clock and reset
  input  wire         sys_clk_i,
  input  wire         rst_n_i,
  // Data
  input  wire [W-1:0] async_i,
  output reg  [W-1:0] sync_o
);

////////////////////////////////////////////////////////////////////////////////
reg [W-1:0] stage1;
reg [W-1:0] stage2;
reg [W-1:0] stage3;
integer     i;

always @(posedge sys_clk_i or negedge rst_n_i) begin
  if (!rst_n_i) begin
    stage1 <= {W{1'b0}};
    stage2 <= {W{1'b0}};
    stage3 <= {W{1'b0}};
    sync_o <= {W{1'b0}};
  end else begin
    stage1 <= async_i;
    stage2 <= stage1;
    stage3 <= stage2;
    for (i = 0; i < W; i = i + 1) begin
      if (stage2[i] == stage3[i]) begin
        sync_o[i] <= stage3[i];
      end
    end
  end
end

endmodule
`default_nettype wire

//--- test/ssfm_top_monitor.sv
// Purpose: Port checker for the safe-stop feedback monitor
// Assumes: 1 us tick of 200 cycles, FILT_TICKS from the bound top
// Notes:   Low-time counters stand in for the release filter
`default_nettype none
module ssfm_top_monitor #(
  parameter int FILT_TICKS = 4
) (
  // Clock and reset
  input wire logic       sys_clk_i,
  input wire logic       rst_n_i,
  // Channels
  input wire logic       safe_stop_in_a_i,
  input wire logic       safe_stop_in_b_i,
  // Drive and fault outputs
  input wire logic       stop_feedback_out_o,
  input wire logic       motor_current_en_o,
  input wire logic       cut_display_o,
  input wire logic [1:0] safe_input_monitor_o,
  input wire logic       fault_out_o,
  input wire logic       fault_code_out_1_o,
  input wire logic       fault_code_out_2_o,
  input wire logic       fault_code_out_3_o,
  input wire logic       fault_oe_o,
  // APB
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready
);
  timeunit 1ns;
  timeprecision 1ps;
  // Filter may finish up to one tick early, cut lands well inside two more
  localparam int MIN_LOW = (FILT_TICKS - 1) * 200;
  localparam int CUT_LOW = (FILT_TICKS + 2) * 200;
  logic [15:0] low_a;
  logic [15:0] low_b;
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      low_a <= 16'h0000;
      low_b <= 16'h0000;
    end else begin
      low_a <= safe_stop_in_a_i ? 16'h0000 : low_a + 16'h0001;
      low_b <= safe_stop_in_b_i ? 16'h0000 : low_b + 16'h0001;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  chk_cut_on_release: assert property ((low_a > CUT_LOW || low_b > CUT_LOW) |-> !motor_current_en_o)
    else $error("motor powered with a channel long released");
  chk_fb_filtered: assert property ($rose(stop_feedback_out_o) |-> low_a >= MIN_LOW && low_b >= MIN_LOW)
    else $error("feedback rose on a short release");
  chk_fb_both_off: assert property ((safe_input_monitor_o != 2'h0)[*3] |-> !stop_feedback_out_o)
    else $error("feedback high with a channel on");
  chk_fb_follows: assert property (($rose(safe_stop_in_a_i) || $rose(safe_stop_in_b_i)) |-> ##[1:8] !stop_feedback_out_o)
    else $error("feedback late to drop");
  chk_cut_shown: assert property (stop_feedback_out_o[*3] |-> cut_display_o && !motor_current_en_o && !fault_oe_o)
    else $error("cut not shown while both released");
  chk_fault_quiet: assert property (!fault_oe_o |-> !(fault_out_o || fault_code_out_1_o || fault_code_out_2_o || fault_code_out_3_o))
    else $error("fault pins active while undriven");
  chk_mon_a_on: assert property (safe_stop_in_a_i[*7] |-> safe_input_monitor_o[0])
    else $error("monitor misses channel a on");
  chk_mon_b_off: assert property (!safe_stop_in_b_i[*7] |-> !safe_input_monitor_o[1])
    else $error("monitor misses channel b off");
  chk_apb_wait: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("apb wait state wrong");
endmodule
bind ssfm_top ssfm_top_monitor #(.FILT_TICKS(FILT_TICKS)) i_mon (.*);
`default_nettype wire

//--- test/ssfm_safety_unit.sv
// Purpose: External safety unit driving both stop channels
// Assumes: Channel high = closed (on)
// Notes:   noise_i opens channel a briefly to model a wiring glitch
`default_nettype none
module ssfm_safety_unit (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Guard requests and feedback
  input wire logic open_a_i,
  input wire logic open_b_i,
  input wire logic noise_i,
  input wire logic fb_i,
  // Channels
  output var logic ch_a_o,
  output var logic ch_b_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic cl_a;
  logic cl_b;
  assign ch_a_o = cl_a & ~noise_i;
  assign ch_b_o = cl_b;
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cl_a <= 1'h1;
      cl_b <= 1'h1;
    end else if (!open_a_i && !open_b_i && fb_i) begin
      cl_a <= 1'h1;
      cl_b <= 1'h1;
    end else begin
      // Without feedback the unit stays open, a stuck channel blocks restart
      cl_a <= cl_a & ~open_a_i;
      cl_b <= cl_b & ~open_b_i;
    end
  end
endmodule
`default_nettype wire

//--- test/ssfm_top_tb_top.sv
// Purpose: Self-checking bench for the safe-stop feedback monitor
// Assumes: Shortened filter and skew counts
// Notes:   Host side lives here, safety unit in its own model
`default_nettype none
`include "ssfm_defines.vh"
module ssfm_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'h0, rst_n = 1'h0, open_a = 1'h0, open_b = 1'h0, noise = 1'h0;
  logic        drv_on = 1'h0, clr = 1'h0, pls = 1'h0, dir = 1'h0;
  logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0, perr;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic [31:0] seed = 32'heec7_a0ab;
  logic        pready, pslverr, ch_a, ch_b, fb, mce, step, mdir, cut, fo, foe, irq;
  logic [1:0]  mon;
  wire logic [2:0] fc;
  int          err_count = 0, comparisons = 0, n, sum, k;
  always #2.5 clk = ~clk;
  ssfm_safety_unit i_unit (.sys_clk_i(clk), .rst_n_i(rst_n), .open_a_i(open_a), .open_b_i(open_b),
    .noise_i(noise), .fb_i(fb), .ch_a_o(ch_a), .ch_b_o(ch_b));
  ssfm_top #(.FILT_TICKS(4), .SKEW_TICKS(50)) i_dut (.sys_clk_i(clk), .rst_n_i(rst_n),
    .safe_stop_in_a_i(ch_a), .safe_stop_in_b_i(ch_b), .stop_feedback_out_o(fb), .drive_on_req_i(drv_on),
    .error_clear_in_i(clr), .pos_ref_pulse_i(pls), .pos_ref_dir_i(dir), .motor_current_en_o(mce),
    .move_step_o(step), .move_dir_o(mdir), .cut_display_o(cut), .safe_input_monitor_o(mon), .fault_out_o(fo),
    .fault_code_out_1_o(fc[0]), .fault_code_out_2_o(fc[1]), .fault_code_out_3_o(fc[2]), .fault_oe_o(foe),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq_o(irq));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic int ref_val(input logic d);
    return d ? -1 : 1;
  endfunction
  task automatic wrap_up();
    $display("err_count %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      err_count++;
      $display("[ERR] %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic limit(input int cnt, input int lim);
    if (cnt >= lim) begin
      chk("wait", 0, 1);
      wrap_up();
    end
  endtask
  // Idle cycle after each transfer keeps psel from being written twice at one edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    for (i = 0; i < 20 && pready !== 1'h1; i++) @(posedge clk);
    limit(i, 20);
    rd = prdata;
    perr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask
  task automatic pulses(input int cnt, input logic rmask);
    logic [31:0] r;
    sum = 0;
    repeat (cnt) begin
      r = rnd();
      dir <= r[0] & rmask;
      sum += ref_val(r[0] & rmask);
      repeat (6) @(posedge clk);
      pls <= 1'h1;
      repeat (6) @(posedge clk);
      pls <= 1'h0;
    end
    repeat (8) @(posedge clk);
  endtask
  task automatic wait_fb();
    for (n = 0; n < 3000 && fb !== 1'h1; n++) @(posedge clk);
    limit(n, 3000);
  endtask
  initial begin
    repeat (90000) @(posedge clk);
    chk("watchdog", 0, 1);
    wrap_up();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    apb(1'h0, `SSFM_REG_CTRL, 32'h0000_0000);
    chk("ctrl", `SSFM_CTRL_RST, rd);
    apb(1'h0, `SSFM_REG_OVF_LIMIT, 32'h0000_0000);
    chk("ovf", `SSFM_OVF_LIMIT_RST, rd);
    apb(1'h0, 12'h040, 32'h0000_0000);
    chk("unmapped", 32'h0000_0001, {rd[30:0], perr});
    apb(1'h1, `SSFM_REG_IRQ_EN, 32'h0000_000F);
    drv_on <= 1'h1;
    repeat (20) @(posedge clk);
    chk("run", 1, mce);
    k = 100 + rnd() % 400;
    noise <= 1'h1;
    repeat (k) @(posedge clk);
    noise <= 1'h0;
    repeat (1500) @(posedge clk);
    chk("glitch", 32'h0000_0001, {irq, mce});
    apb(1'h1, `SSFM_REG_CTRL, 32'h0000_0001);
    apb(1'h1, `SSFM_REG_OVF_LIMIT, 32'h0000_0005);
    open_a <= 1'h1;
    open_b <= 1'h1;
    wait_fb();
    repeat (4) @(posedge clk);
    chk("cut", 32'h0000_0005, {cut, mce, irq});
    chk("mon", 0, mon);
    pulses(7, 1'h0);
    apb(1'h0, `SSFM_REG_POS_ERR, 32'h0000_0000);
    chk("keep", 7, rd);
    apb(1'h0, `SSFM_REG_STATUS, 32'h0000_0000);
    chk("ovr", 1, rd[9]);
    chk("quiet", 0, {foe, fo, fc});
    clr <= 1'h1;
    repeat (10) @(posedge clk);
    clr <= 1'h0;
    repeat (10) @(posedge clk);
    apb(1'h0, `SSFM_REG_POS_ERR, 32'h0000_0000);
    chk("clear", 0, rd);
    apb(1'h1, `SSFM_REG_FAULT_CLR, 32'h0000_0004);
    apb(1'h1, `SSFM_REG_OVF_LIMIT, 32'h0000_03E8);
    pulses(1 + rnd() % 6, 1'h1);
    apb(1'h0, `SSFM_REG_POS_ERR, 32'h0000_0000);
    chk("retain", sum, rd);
    open_a <= 1'h0;
    open_b <= 1'h0;
    drv_on <= 1'h0;
    repeat (300) @(posedge clk);
    apb(1'h0, `SSFM_REG_STATUS, 32'h0000_0000);
    chk("idle", 0, rd[1:0]);
    drv_on <= 1'h1;
    k = 0;
    repeat (2000) begin
      @(posedge clk);
      k += step;
    end
    chk("moved", sum < 0 ? -sum : sum, k);
    chk("dir", sum > 0, mdir);
    apb(1'h1, `SSFM_REG_CTRL, 32'h0000_0000);
    open_a <= 1'h1;
    repeat (1500) @(posedge clk);
    chk("lone_cut", 0, mce);
    pulses(3, 1'h1);
    apb(1'h0, `SSFM_REG_POS_ERR, 32'h0000_0000);
    chk("cut_clear", 0, rd);
    apb(1'h0, `SSFM_REG_STATUS, 32'h0000_0000);
    chk("skew_early", 0, rd[8]);
    for (n = 0; n < 12 && rd[8] !== 1'h1; n++) begin
      repeat (1000) @(posedge clk);
      apb(1'h0, `SSFM_REG_STATUS, 32'h0000_0000);
    end
    limit(n, 12);
    chk("skew", 32'h0000_0003, {rd[8], irq});
    apb(1'h0, `SSFM_REG_IRQ_STAT, 32'h0000_0000);
    chk("skew_ev", 1, rd[`SSFM_EV_SKEW]);
    apb(1'h1, `SSFM_REG_IRQ_EN, 32'h0000_0000);
    repeat (2) @(posedge clk);
    chk("masked", 0, irq);
    apb(1'h1, `SSFM_REG_IRQ_CLR, 32'h0000_000F);
    apb(1'h1, `SSFM_REG_IRQ_EN, 32'h0000_000F);
    repeat (2) @(posedge clk);
    chk("cleared", 0, irq);
    open_b <= 1'h1;
    wait_fb();
    open_a <= 1'h0;
    open_b <= 1'h0;
    drv_on <= 1'h0;
    repeat (300) @(posedge clk);
    chk("fault_pins", {2'h3, `SSFM_CODE_SKEW}, {foe, fo, fc});
    wrap_up();
  end
endmodule
`default_nettype wire
